// >>> core/sbio_top.v
// Six-bit bidirectional I/O port pair as seen by the processor core:
// port data registers on the file register bus, direction loads, pin drive.
// Assumes the core gives one-cycle read, write and direction-load strobes
// on CORE_CLK_IN; pull-up and wake enables and configuration come as levels.
//
// Function
// - Port read returns the pin levels, never the output latch contents.
// - Primary port register is eight bits; upper two bits read zero.
// - Pin three is input only; its driver never turns on.
// - Pins given to an alternate function read as zero.
// - Pins 0, 1, 3, 4 share one pull-up enable and one wake-up enable.
// - Pin three as master reset: pull-up forced on, no wake-up.
// - Second port maps six pins; upper two bits read zero.
// - Timer clock input owns second-port pin five until deselected.
// - Direction load copies the working register into the chosen direction bits.
// - Direction one means high impedance; zero drives the latch value.
// - Direction bits are write only and set by every reset.
// - Output latches keep their value until the port is written again or a reset clears them.
// - Every pin has its own direction bit; the bit of pin three is overridden.
// - Write lands at the strobe edge; read samples settled pins.
`include "sbio_regs.vh"

module sbio_top #(
  parameter HAS_SECOND_PORT = 1,
  parameter WIDTH = `SBIO_PORT_W
) (
  input wire CORE_CLK_IN,
  input wire RST_B_IN,
  input wire [4:0] REG_ADDR_IN,
  input wire [7:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  output wire [7:0] REG_RDATA_OUT,
  input wire DIR_LOAD_IN,
  input wire [4:0] DIR_SEL_IN,
  input wire [7:0] WORK_REG_IN,
  input wire PULLUP_WAKE_EN_IN,
  input wire WAKE_EN_IN,
  input wire MASTER_RESET_INPUT_EN_IN,
  input wire TIMER_CLK_SEL_IN,
  input wire [5:0] PRI_ALT_FUNC_IN,
  input wire [5:0] SEC_ALT_FUNC_IN,
  input wire [5:0] PRI_PIN_IN,
  output wire [5:0] PRI_PIN_OUT,
  output wire [5:0] PRI_PIN_OE_B_OUT,
  input wire [5:0] SEC_PIN_IN,
  output wire [5:0] SEC_PIN_OUT,
  output wire [5:0] SEC_PIN_OE_B_OUT,
  output wire [5:0] PULLUP_EN_OUT,
  output wire WAKE_OUT
);

  function hit;
    input [4:0] addr;
    input [4:0] code;
    begin
      hit = (addr == code);
    end
  endfunction

  // Turns a level enable into a pin mask
  function [WIDTH-1:0] mask_if;
    input en;
    input [WIDTH-1:0] mask;
    begin
      mask_if = en ? mask : {WIDTH{1'b0}};
    end
  endfunction

  // Second port present: secondary strobes are honoured only then
  localparam SEC_ON = (HAS_SECOND_PORT != 0) ? 1'b1 : 1'b0;

  wire [WIDTH-1:0] pri_level;
  wire [WIDTH-1:0] sec_level;
  wire [WIDTH-1:0] sec_pin_raw;
  wire [WIDTH-1:0] sec_oe_b_raw;
  wire [WIDTH-1:0] pri_force;
  wire [WIDTH-1:0] sec_force;
  wire [WIDTH-1:0] pri_alt;
  wire [WIDTH-1:0] pri_read;
  wire [WIDTH-1:0] sec_read;
  wire [WIDTH-1:0] wake_mask;
  wire [WIDTH-1:0] group_mask;
  wire pri_wr;
  wire sec_wr;
  wire pri_dir_ld;
  wire sec_dir_ld;
  wire pri_rd;
  wire [WIDTH-1:0] mr_mask;

  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;
  reg [WIDTH-1:0] snap_ff;
  reg snap_valid_ff;
  reg wake_ff;
  reg nxt_wake;
  reg pri_sel;
  reg sec_sel;

  // One address decode serves read and write; other addresses answer nothing
  always @* begin
    pri_sel = 1'b0;
    sec_sel = 1'b0;
    case (REG_ADDR_IN)
      `SBIO_PRI_ADDR: begin
        pri_sel = 1'b1;
      end
      `SBIO_SEC_ADDR: begin
        sec_sel = SEC_ON;
      end
      default: begin
        pri_sel = 1'b0;
        sec_sel = 1'b0;
      end
    endcase
  end

  assign pri_wr = REG_WR_IN & pri_sel;
  assign sec_wr = REG_WR_IN & sec_sel;
  assign pri_rd = REG_RD_IN & pri_sel;
  assign pri_dir_ld = DIR_LOAD_IN & hit(DIR_SEL_IN, `SBIO_PRI_ADDR);
  assign sec_dir_ld = DIR_LOAD_IN & hit(DIR_SEL_IN, `SBIO_SEC_ADDR) & SEC_ON;

  // Pin three is input only, whatever its direction bit holds
  assign pri_force = `SBIO_INPUT_ONLY_MASK;
  // The timer clock input keeps pin five until software deselects it
  assign sec_force = mask_if(TIMER_CLK_SEL_IN, `SBIO_TIMER_CLK_MASK);
  // Pin three as master reset: pull-up forced, no wake, reads zero
  assign mr_mask = mask_if(MASTER_RESET_INPUT_EN_IN, `SBIO_INPUT_ONLY_MASK);

  sbio_port #(
    .WIDTH(WIDTH)
  ) u_pri (
    .clk_in(CORE_CLK_IN),
    .rst_b_in(RST_B_IN),
    .latch_wr_in(pri_wr),
    .latch_data_in(REG_WDATA_IN[WIDTH-1:0]),
    .dir_ld_in(pri_dir_ld),
    .dir_data_in(WORK_REG_IN[WIDTH-1:0]),
    .force_input_in(pri_force),
    .pin_in(PRI_PIN_IN),
    .pin_out(PRI_PIN_OUT),
    .pin_oe_b_out(PRI_PIN_OE_B_OUT),
    .level_out(pri_level)
  );

  sbio_port #(
    .WIDTH(WIDTH)
  ) u_sec (
    .clk_in(CORE_CLK_IN),
    .rst_b_in(RST_B_IN),
    .latch_wr_in(sec_wr),
    .latch_data_in(REG_WDATA_IN[WIDTH-1:0]),
    .dir_ld_in(sec_dir_ld),
    .dir_data_in(WORK_REG_IN[WIDTH-1:0]),
    .force_input_in(sec_force),
    .pin_in(SEC_PIN_IN),
    .pin_out(sec_pin_raw),
    .pin_oe_b_out(sec_oe_b_raw),
    .level_out(sec_level)
  );

  // Without a second port its pins stay undriven
  assign SEC_PIN_OUT = (HAS_SECOND_PORT != 0) ? sec_pin_raw : `SBIO_ZERO6;
  assign SEC_PIN_OE_B_OUT = (HAS_SECOND_PORT != 0) ? sec_oe_b_raw : `SBIO_DIR_RST;

  // Master reset on pin three is an alternate function, so it reads zero
  assign pri_alt = PRI_ALT_FUNC_IN | mr_mask;
  assign pri_read = pri_level & ~pri_alt;
  assign sec_read = sec_level & ~SEC_ALT_FUNC_IN;

  // Read data come from the settled pin levels at the strobe; nothing is held
  // per pin, so an input pulse gone before the strobe is missed
  always @* begin
    nxt_rdata = rdata_ff;
    if (REG_RD_IN) begin
      if (pri_sel) begin
        nxt_rdata = {`SBIO_UNUSED_HI, pri_read};
      end else if (sec_sel) begin
        nxt_rdata = {`SBIO_UNUSED_HI, sec_read};
      end else begin
        // Other addresses and direction bits have no read path here
        nxt_rdata = `SBIO_READ_IDLE;
      end
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      rdata_ff <= `SBIO_READ_IDLE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA_OUT = rdata_ff;

  // One enable serves the whole group; pin three's pull-up is forced as reset
  assign group_mask = mask_if(PULLUP_WAKE_EN_IN, `SBIO_GROUP_MASK);
  assign PULLUP_EN_OUT = group_mask | mr_mask;
  assign wake_mask = mask_if(WAKE_EN_IN, `SBIO_GROUP_MASK) & ~mr_mask;

  // Wake compares pins with the value of the last primary read; until one
  // read has been made there is no reference, so no wake is raised
  always @* begin
    nxt_wake = snap_valid_ff & (|((pri_level ^ snap_ff) & wake_mask));
  end

  always @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      snap_ff <= `SBIO_ZERO6;
      snap_valid_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      if (pri_rd) begin
        snap_ff <= pri_level;
        snap_valid_ff <= 1'b1;
      end
      wake_ff <= nxt_wake;
    end
  end

  assign WAKE_OUT = wake_ff;

endmodule // sbio_top

// >>> core/sbio_regs.vh
// Constants for the six-bit bidirectional I/O port block.
// Assumes inclusion by bare name from the core/ design files only.
`ifndef SBIO_REGS_VH
`define SBIO_REGS_VH

// File register addresses of the two port registers
`define SBIO_ADDR_W 5
`define SBIO_PRI_ADDR 5'h06
`define SBIO_SEC_ADDR 5'h07

// Port register layout: six pin bits, two upper bits read as zero
`define SBIO_REG_W 8
`define SBIO_PORT_W 6
`define SBIO_UNUSED_HI 2'h0
`define SBIO_READ_IDLE 8'h00

// Reset values
`define SBIO_DIR_RST 6'h3f
`define SBIO_LATCH_RST 6'h00
`define SBIO_ZERO6 6'h00

// Pin positions and groups
`define SBIO_INPUT_ONLY_BIT 3
`define SBIO_TIMER_CLK_BIT 5
`define SBIO_INPUT_ONLY_MASK 6'h08
`define SBIO_TIMER_CLK_MASK 6'h20
`define SBIO_GROUP_MASK 6'h1b

`endif

// >>> core/sbio_port.v
// One six-bit port slice: output latches, direction bits, pin input
// synchroniser and driver enables. Instantiated once per port.
// Assumes strobes come from logic on the same clock; pin inputs are asynchronous.
`include "sbio_regs.vh"

module sbio_port #(
  parameter WIDTH = `SBIO_PORT_W
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire latch_wr_in,
  input wire [WIDTH-1:0] latch_data_in,
  input wire dir_ld_in,
  input wire [WIDTH-1:0] dir_data_in,
  input wire [WIDTH-1:0] force_input_in,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out,
  output wire [WIDTH-1:0] pin_oe_b_out,
  output wire [WIDTH-1:0] level_out
);

  // A bit changes only once the second and third stage agree
  function [WIDTH-1:0] agree;
    input [WIDTH-1:0] s2;
    input [WIDTH-1:0] s3;
    input [WIDTH-1:0] old;
    begin
      agree = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & old);
    end
  endfunction

  reg [WIDTH-1:0] latch_ff;
  reg [WIDTH-1:0] dir_ff;
  reg [WIDTH-1:0] sync1_ff;
  reg [WIDTH-1:0] sync2_ff;
  reg [WIDTH-1:0] sync3_ff;
  reg [WIDTH-1:0] level_ff;

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      latch_ff <= `SBIO_LATCH_RST;
      dir_ff <= `SBIO_DIR_RST;
    end else begin
      // Every bit is written, inputs too, so a later switch to output shows it
      if (latch_wr_in) begin
        latch_ff <= latch_data_in;
      end
      if (dir_ld_in) begin
        dir_ff <= dir_data_in;
      end
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      sync1_ff <= `SBIO_ZERO6;
      sync2_ff <= `SBIO_ZERO6;
      sync3_ff <= `SBIO_ZERO6;
      level_ff <= `SBIO_ZERO6;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      level_ff <= agree(sync2_ff, sync3_ff, level_ff);
    end
  end

  assign pin_out = latch_ff;
  // Enable is low while driving; forced bits never drive
  assign pin_oe_b_out = dir_ff | force_input_in;
  assign level_out = level_ff;

endmodule // sbio_port

// >>> tb/sbio_asserts.sv
// Concurrent checks on the port pair's top-level pins.
// Assumes it is bound to sbio_top and sees only its ports.
module sbio_asserts (
  input wire CORE_CLK_IN,
  input wire RST_B_IN,
  input wire [4:0] REG_ADDR_IN,
  input wire [7:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  input wire [7:0] REG_RDATA_OUT,
  input wire DIR_LOAD_IN,
  input wire [4:0] DIR_SEL_IN,
  input wire [7:0] WORK_REG_IN,
  input wire PULLUP_WAKE_EN_IN,
  input wire MASTER_RESET_INPUT_EN_IN,
  input wire TIMER_CLK_SEL_IN,
  input wire [5:0] PRI_PIN_OUT,
  input wire [5:0] PRI_PIN_OE_B_OUT,
  input wire [5:0] SEC_PIN_OE_B_OUT,
  input wire [5:0] PULLUP_EN_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  sequence s_pri_wr;
    REG_WR_IN && REG_ADDR_IN == 5'h06;
  endsequence
  sequence s_pri_dir;
    DIR_LOAD_IN && DIR_SEL_IN == 5'h06;
  endsequence
  a_upper_zero: assert property (REG_RDATA_OUT[7:6] == 2'h0)
    else $error("upper read bits set");
  a_input_only: assert property (PRI_PIN_OE_B_OUT[3])
    else $error("input-only pin driven");
  a_dir_load: assert property (s_pri_dir |=>
    {2'h0, PRI_PIN_OE_B_OUT} == ($past(WORK_REG_IN) & 8'h3f | 8'h08))
    else $error("direction load wrong");
  a_write_latch: assert property (s_pri_wr |=>
    {2'h0, PRI_PIN_OUT} == ($past(REG_WDATA_IN) & 8'h3f))
    else $error("latch write wrong");
  a_latch_hold: assert property (!(REG_WR_IN && REG_ADDR_IN == 5'h06) |=>
    $stable(PRI_PIN_OUT)) else $error("latch changed unwritten");
  a_pullup_group: assert property (PULLUP_EN_OUT == {1'b0, PULLUP_WAKE_EN_IN,
    PULLUP_WAKE_EN_IN | MASTER_RESET_INPUT_EN_IN, 1'b0, {2{PULLUP_WAKE_EN_IN}}})
    else $error("pull-up group wrong");
  a_timer_owns: assert property (TIMER_CLK_SEL_IN |-> SEC_PIN_OE_B_OUT[5])
    else $error("timer pin driven");
  a_rdata_hold: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT))
    else $error("read data changed");
endmodule // sbio_asserts

bind sbio_top sbio_asserts chk (.CORE_CLK_IN, .RST_B_IN, .REG_ADDR_IN, .REG_WDATA_IN,
  .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .DIR_LOAD_IN, .DIR_SEL_IN, .WORK_REG_IN,
  .PULLUP_WAKE_EN_IN, .MASTER_RESET_INPUT_EN_IN, .TIMER_CLK_SEL_IN, .PRI_PIN_OUT,
  .PRI_PIN_OE_B_OUT, .SEC_PIN_OE_B_OUT, .PULLUP_EN_OUT);

// >>> tb/sbio_pins.sv
// Circuits outside one six-pin port.
// Assumes the bench says which pins it holds and at what level.
module sbio_pins (
  input wire clk_in,
  input wire [5:0] drv_in,
  input wire [5:0] oe_b_in,
  input wire [5:0] pull_in,
  input wire [5:0] ext_in,
  input wire [5:0] hold_in,
  output logic [5:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] float_ff = 6'h00;
  // A floating pin toggles each cycle; the port's input filter then holds its last settled level
  always @(posedge clk_in) float_ff <= ~float_ff;
  // Held levels win even over a live driver and stay while hold_in is set
  assign level_out = hold_in & ext_in
                     | ~hold_in & (~oe_b_in & drv_in | oe_b_in & (pull_in | float_ff));
endmodule // sbio_pins

// >>> tb/sbio_top_tb_top.sv
// Self-checking bench for the six-bit port pair.
// Assumes a 100 MHz core clock and pin models from sbio_pins.
module sbio_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK_IN = 1'b0, RST_B_IN = 1'b0, REG_WR_IN = 1'b0, REG_RD_IN = 1'b0;
  logic DIR_LOAD_IN = 1'b0, PULLUP_WAKE_EN_IN = 1'b0, WAKE_EN_IN = 1'b1, rd_seen = 1'b0;
  logic MASTER_RESET_INPUT_EN_IN = 1'b0, TIMER_CLK_SEL_IN = 1'b1;
  logic [4:0] REG_ADDR_IN = 5'h00, DIR_SEL_IN = 5'h00;
  logic [7:0] REG_WDATA_IN = 8'h00, WORK_REG_IN = 8'h00, d;
  logic [5:0] PRI_ALT_FUNC_IN = 6'h00, SEC_ALT_FUNC_IN = 6'h00, pext = 6'h00, sext = 6'h00;
  logic [5:0] phold = 6'h3f, shold = 6'h3f, pdir = 6'h3f, sdir, plat = 6'h00, slat = 6'h00;
  wire [7:0] REG_RDATA_OUT;
  wire [5:0] PRI_PIN_IN, PRI_PIN_OUT, PRI_PIN_OE_B_OUT, SEC_PIN_IN, SEC_PIN_OUT;
  wire [5:0] SEC_PIN_OE_B_OUT, PULLUP_EN_OUT;
  wire WAKE_OUT;
  logic [7:0] q[$];
  int fails = 0, checks = 0;
  int unsigned seed = 25;

  sbio_top dut (.CORE_CLK_IN, .RST_B_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN,
    .REG_RDATA_OUT, .DIR_LOAD_IN, .DIR_SEL_IN, .WORK_REG_IN, .PULLUP_WAKE_EN_IN, .WAKE_EN_IN,
    .MASTER_RESET_INPUT_EN_IN, .TIMER_CLK_SEL_IN, .PRI_ALT_FUNC_IN, .SEC_ALT_FUNC_IN,
    .PRI_PIN_IN, .PRI_PIN_OUT, .PRI_PIN_OE_B_OUT, .SEC_PIN_IN, .SEC_PIN_OUT,
    .SEC_PIN_OE_B_OUT, .PULLUP_EN_OUT, .WAKE_OUT);
  sbio_pins pri_pins (.clk_in(CORE_CLK_IN), .drv_in(PRI_PIN_OUT), .oe_b_in(PRI_PIN_OE_B_OUT),
    .pull_in(PULLUP_EN_OUT), .ext_in(pext), .hold_in(phold), .level_out(PRI_PIN_IN));
  sbio_pins sec_pins (.clk_in(CORE_CLK_IN), .drv_in(SEC_PIN_OUT), .oe_b_in(SEC_PIN_OE_B_OUT),
    .pull_in(6'h00), .ext_in(sext), .hold_in(shold), .level_out(SEC_PIN_IN));

  initial forever #5 CORE_CLK_IN = ~CORE_CLK_IN;

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic op(input logic w, r, l, input logic [4:0] a, input logic [7:0] v);
    @(posedge CORE_CLK_IN);
    REG_WR_IN <= w;
    REG_RD_IN <= r;
    DIR_LOAD_IN <= l;
    REG_ADDR_IN <= a;
    DIR_SEL_IN <= a;
    REG_WDATA_IN <= v;
    WORK_REG_IN <= v;
    @(posedge CORE_CLK_IN);
    REG_WR_IN <= 1'b0;
    REG_RD_IN <= 1'b0;
    DIR_LOAD_IN <= 1'b0;
    #1;
  endtask

  task automatic stop_test();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Read data lands one edge after the strobe; oldest note is its match
  always @(posedge CORE_CLK_IN) rd_seen <= REG_RD_IN;
  always @(negedge CORE_CLK_IN) if (rd_seen) chk(REG_RDATA_OUT, q.pop_front());

  initial begin
    #20000;
    fails++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge CORE_CLK_IN);
    RST_B_IN <= 1'b1;
    #1 chk({2'h0, PRI_PIN_OE_B_OUT}, 8'h3f);
    op(0, 0, 1, 5'h07, 8'h00);
    sdir = 6'h00;
    chk({2'h0, SEC_PIN_OE_B_OUT}, 8'h20);
    @(posedge CORE_CLK_IN) TIMER_CLK_SEL_IN <= 1'b0;
    @(posedge CORE_CLK_IN) #1 chk({2'h0, SEC_PIN_OE_B_OUT}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      op(1, 0, 0, 5'h06, rnd());
      plat = REG_WDATA_IN[5:0];
      chk({2'h0, PRI_PIN_OUT}, {2'h0, plat});
      op(0, 0, 1, 5'h06, rnd());
      pdir = WORK_REG_IN[5:0] | 6'h08;
      chk({2'h0, PRI_PIN_OE_B_OUT}, {2'h0, pdir});
      op(1, 0, 0, 5'h07, rnd());
      slat = REG_WDATA_IN[5:0];
      chk({2'h0, SEC_PIN_OUT}, {2'h0, slat});
      op(0, 0, 1, 5'h07, rnd());
      sdir = WORK_REG_IN[5:0];
      chk({2'h0, SEC_PIN_OE_B_OUT}, {2'h0, sdir});
      d = rnd();
      pext = d[5:0];
      @(posedge CORE_CLK_IN) PRI_ALT_FUNC_IN <= d[5:0] & d[7:2];
      d = rnd();
      sext = d[5:0];
      SEC_ALT_FUNC_IN <= d[5:0] & ~d[7:2];
      phold = pdir;
      shold = sdir;
      repeat (5) @(posedge CORE_CLK_IN);
      q.push_back({2'h0, (pdir & pext | ~pdir & plat) & ~PRI_ALT_FUNC_IN});
      op(0, 1, 0, 5'h06, 8'h00);
      q.push_back({2'h0, (sdir & sext | ~sdir & slat) & ~SEC_ALT_FUNC_IN});
      op(0, 1, 0, 5'h07, 8'h00);
    end
    op(1, 0, 0, 5'h1f, 8'hff);
    chk({2'h0, PRI_PIN_OUT}, {2'h0, plat});
    // Pin 0 driven high but held low outside; pin 3 floats on its pull-up
    op(1, 0, 0, 5'h06, 8'hff);
    op(0, 0, 1, 5'h06, 8'h00);
    phold = 6'h01;
    pext = 6'h00;
    @(posedge CORE_CLK_IN);
    PULLUP_WAKE_EN_IN <= 1'b1;
    PRI_ALT_FUNC_IN <= 6'h00;
    #1 chk({2'h0, PULLUP_EN_OUT}, 8'h1b);
    repeat (5) @(posedge CORE_CLK_IN);
    q.push_back(8'h3e);
    op(0, 1, 0, 5'h06, 8'h00);
    // The read just taken is the wake reference; a group pin change wakes
    @(posedge CORE_CLK_IN) #1 chk({7'h00, WAKE_OUT}, 8'h00);
    pext = 6'h01;
    repeat (6) @(posedge CORE_CLK_IN);
    #1 chk({7'h00, WAKE_OUT}, 8'h01);
    @(posedge CORE_CLK_IN);
    PULLUP_WAKE_EN_IN <= 1'b0;
    MASTER_RESET_INPUT_EN_IN <= 1'b1;
    #1 chk({2'h0, PULLUP_EN_OUT}, 8'h08);
    repeat (5) @(posedge CORE_CLK_IN);
    q.push_back(8'h37);
    op(0, 1, 0, 5'h06, 8'h00);
    @(posedge CORE_CLK_IN) RST_B_IN <= 1'b0;
    repeat (2) @(posedge CORE_CLK_IN);
    #1 chk({2'h0, PRI_PIN_OE_B_OUT}, 8'h3f);
    stop_test();
  end
endmodule // sbio_top_tb_top
